// [core/usbg_top.v]
// two-channel receive error status and baud rate generator
`timescale 1ns/10ps
`default_nettype none
`include "usbg_consts.vh"
module usbg_top #(
  parameter NCH = 2
) (
  input wire I_CLK_SYS,
  input wire I_RESETN,
  input wire [15:0] I_ADDR,
  input wire I_WR,
  input wire I_RD,
  input wire [7:0] I_WDATA,
  output reg [7:0] O_RDATA,
  input wire [NCH-1:0] I_RX_DONE,
  input wire [NCH-1:0] I_RX_PAR_BIT,
  input wire [NCH-1:0] I_RX_DATA_PAR,
  input wire [NCH-1:0] I_RX_STOP_BIT,
  input wire [2*NCH-1:0] I_PARITY_MODE,
  input wire [NCH-1:0] I_RXBUF_READ,
  input wire I_ERROR_IRQ_SUPPRESS,
  output wire [NCH-1:0] O_TX_PARITY,
  output reg [NCH-1:0] O_BAUD_TICK,
  output reg [NCH-1:0] O_RX_END_IRQ
);
  localparam data_w = `USBG_DATA_W;
  localparam pre_w = `USBG_PRE_W;
  localparam cnt_w = `USBG_CNT_W;

  // flattened per-channel views for the read mux
  wire [data_w*NCH-1:0] stat_all;
  wire [data_w*NCH-1:0] brg_all;

  // per-channel pulses, registered below in one place
  wire [NCH-1:0] tick_nxt;
  wire [NCH-1:0] irq_nxt;

  reg [data_w-1:0] rdata_nxt;

  always @* begin
    rdata_nxt = `USBG_RESET_VAL;
    case (I_ADDR)
      `USBG_ADDR_STAT0: begin
        rdata_nxt = stat_all[0 +: data_w];
      end
      `USBG_ADDR_BRG0: begin
        rdata_nxt = brg_all[0 +: data_w];
      end
      `USBG_ADDR_STAT1: begin
        rdata_nxt = stat_all[data_w +: data_w];
      end
      `USBG_ADDR_BRG1: begin
        rdata_nxt = brg_all[data_w +: data_w];
      end
      default: begin
        rdata_nxt = `USBG_RESET_VAL;
      end
    endcase
  end

  // read data holds until the next read strobe
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      O_RDATA <= `USBG_RESET_VAL;
    end else if (I_RD) begin
      O_RDATA <= rdata_nxt;
    end
  end

  // one driver for each pulse vector
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      O_BAUD_TICK <= {NCH{1'b0}};
    end else begin
      O_BAUD_TICK <= tick_nxt;
    end
  end

  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      O_RX_END_IRQ <= {NCH{1'b0}};
    end else begin
      O_RX_END_IRQ <= irq_nxt;
    end
  end

  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      reg [data_w-1:0] stat_r;
      reg [data_w-1:0] brg_r;
      reg ovr_pend_r;
      reg [pre_w-1:0] pre_r;
      reg [cnt_w-1:0] cnt_r;
      reg half_r;

      wire [data_w-1:0] stat_nxt;
      wire [data_w-1:0] brg_nxt;
      wire ovr_pend_nxt;
      wire [pre_w-1:0] pre_nxt;
      wire [cnt_w-1:0] cnt_nxt;
      wire half_nxt;

      // register address and write strobe
      wire [`USBG_ADDR_W-1:0] brg_addr;
      wire brg_wr;
      assign brg_addr = (c == 0) ? `USBG_ADDR_BRG0 : `USBG_ADDR_BRG1;
      assign brg_wr = I_WR & (I_ADDR == brg_addr);

      // control fields
      wire [`USBG_TPS_W-1:0] tps;
      wire [`USBG_K_W-1:0] k;
      assign tps = brg_r[`USBG_TPS_HI:`USBG_TPS_LO];
      assign k = brg_r[`USBG_K_HI:`USBG_K_LO];

      // whole-byte write, bit 7 forced to zero
      assign brg_nxt = brg_wr ? (I_WDATA & `USBG_BRG_MASK) : brg_r;

      // channel 1 sits one extra halving lower
      wire [`USBG_M_W-1:0] m_ofs;
      wire [`USBG_M_W-1:0] m;
      assign m_ofs = (c == 0) ? `USBG_M_OFS0 : `USBG_M_OFS1;
      assign m = {1'b0, tps} + m_ofs;

      // prescaler runs from the system clock alone
      wire [pre_w-1:0] pre_one;
      wire [pre_w-1:0] pre_last;
      wire pre_tick;
      assign pre_one = {{(pre_w-1){1'b0}}, 1'b1};
      assign pre_last = (pre_one << m) - pre_one;
      // >= so a smaller new divide never waits for a full wrap
      assign pre_tick = (pre_r >= pre_last);
      assign pre_nxt = pre_tick ? {pre_w{1'b0}} : pre_r + pre_one;

      // 5-bit counter divides by 16 plus k
      wire [cnt_w-1:0] cnt_one;
      wire [cnt_w-1:0] cnt_last;
      wire cnt_wrap;
      assign cnt_one = {{(cnt_w-1){1'b0}}, 1'b1};
      // all-ones k is prohibited; it merely divides by 31
      assign cnt_last = `USBG_K_BASE + {1'b0, k} - cnt_one;
      assign cnt_wrap = pre_tick & (cnt_r >= cnt_last);
      assign cnt_nxt = !pre_tick ? cnt_r :
        (cnt_wrap ? {cnt_w{1'b0}} : cnt_r + cnt_one);

      // last halving gives fx over 2^(m+1)(k+16)
      assign half_nxt = cnt_wrap ? ~half_r : half_r;
      assign tick_nxt[c] = cnt_wrap & half_r;

      // parity check, modes 00 and 01 never err
      wire [`USBG_PMODE_W-1:0] pmode;
      wire xor_match;
      wire pe;
      assign pmode = I_PARITY_MODE[`USBG_PMODE_W*c +: `USBG_PMODE_W];
      assign xor_match = (I_RX_PAR_BIT[c] == I_RX_DATA_PAR[c]);
      assign pe = ((pmode == `USBG_PAR_ODD) & xor_match) |
        ((pmode == `USBG_PAR_EVEN) & ~xor_match);

      // only the first stop bit is looked at
      wire fe;
      assign fe = ~I_RX_STOP_BIT[c];

      // overrun while the buffer is still unread
      wire ove;
      assign ove = ovr_pend_r;
      // a new frame beats a same-cycle buffer read
      assign ovr_pend_nxt = I_RX_DONE[c] ? 1'b1 :
        (I_RXBUF_READ[c] ? 1'b0 : ovr_pend_r);

      // flags replaced at frame end only
      wire [data_w-1:0] bit_one;
      wire [data_w-1:0] err_word;
      assign bit_one = {{(data_w-1){1'b0}}, 1'b1};
      assign err_word = ({data_w{pe}} & (bit_one << `USBG_BIT_PE)) |
        ({data_w{fe}} & (bit_one << `USBG_BIT_FE)) |
        ({data_w{ove}} & (bit_one << `USBG_BIT_OVE));
      assign stat_nxt = I_RX_DONE[c] ? err_word : stat_r;

      // only channel 0 may hold back the irq
      wire any_err;
      wire sup_here;
      assign any_err = pe | fe | ove;
      assign sup_here = (c == 0) & I_ERROR_IRQ_SUPPRESS;
      assign irq_nxt[c] = I_RX_DONE[c] & ~(sup_here & any_err);

      assign O_TX_PARITY[c] = `USBG_TX_ZERO_PAR;

      assign stat_all[data_w*c +: data_w] = stat_r;
      assign brg_all[data_w*c +: data_w] = brg_r;

      always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
          stat_r <= `USBG_RESET_VAL;
        end else begin
          stat_r <= stat_nxt;
        end
      end

      always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
          brg_r <= `USBG_RESET_VAL;
        end else begin
          brg_r <= brg_nxt;
        end
      end

      always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
          ovr_pend_r <= 1'b0;
        end else begin
          ovr_pend_r <= ovr_pend_nxt;
        end
      end

      always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
          pre_r <= {pre_w{1'b0}};
        end else begin
          pre_r <= pre_nxt;
        end
      end

      always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
          cnt_r <= {cnt_w{1'b0}};
          half_r <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          half_r <= half_nxt;
        end
      end
    end
  endgenerate
endmodule // usbg_top
`default_nettype wire

// [common/usbg_consts.vh]
// constants for the serial error status and baud generator block
// Summary of operation
// - Each channel's receive error status register is an 8-bit whole-byte read that reset clears to zero.
// - The parity error flag is set when a received parity bit disagrees with the channel's parity mode.
// - The framing error flag is set when no valid stop bit is seen where expected.
// - On receive only the first stop bit is checked, even with two stop bits set for transmit.
// - The overrun error flag is set when a frame completes before the previous byte was read.
// - Until the receive buffer is read every further completed frame reports overrun again.
// - Each baud generator control register is an 8-bit whole-byte write, resets to zero, bit 7 reads zero.
// - A 3-bit prescaler picks a power-of-two division, 2 to 256 on channel 0 and 4 to 512 on channel 1.
// - A 4-bit value k makes the counter divide by 16 plus k; the all-ones code is prohibited.
// - The bit clock is derived from the system clock alone.
// - The baud rate is the system clock over two to the m plus one, times k plus 16.
// - Parity mode 01 appends a zero parity bit on transmit and never raises a parity error.
// - On channel 0 a control bit decides whether receive errors suppress the reception-end interrupt.
`ifndef USBG_CONSTS_VH
`define USBG_CONSTS_VH
`define USBG_ADDR_W 16
`define USBG_ADDR_STAT0 16'hFFA1
`define USBG_ADDR_BRG0 16'hFFA2
`define USBG_ADDR_STAT1 16'hFFA9
`define USBG_ADDR_BRG1 16'hFFAA
`define USBG_RESET_VAL 8'h00
`define USBG_BIT_OVE 0
`define USBG_BIT_FE 1
`define USBG_BIT_PE 2
`define USBG_BRG_MASK 8'h7F
`define USBG_PAR_NONE 2'h0
`define USBG_PAR_ZERO 2'h1
`define USBG_PAR_ODD 2'h2
`define USBG_PAR_EVEN 2'h3
`define USBG_K_BASE 5'h10
`define USBG_PRE_W 10
`define USBG_DATA_W 8
`define USBG_CNT_W 5
`define USBG_TPS_W 3
`define USBG_TPS_HI 6
`define USBG_TPS_LO 4
`define USBG_K_W 4
`define USBG_K_HI 3
`define USBG_K_LO 0
`define USBG_M_W 4
`define USBG_M_OFS0 4'h1
`define USBG_M_OFS1 4'h2
`define USBG_PMODE_W 2
`define USBG_TX_ZERO_PAR 1'h0
`endif

// [verif/usbg_chk_asserts.sv]
// port checker for the status and baud block
`timescale 1ns/10ps
`default_nettype none
module usbg_chk #(
  parameter NCH = 2
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_RD,
  input wire logic I_ERROR_IRQ_SUPPRESS,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] O_RDATA,
  input wire logic [NCH-1:0] I_RX_DONE,
  input wire logic [NCH-1:0] I_RX_STOP_BIT,
  input wire logic [NCH-1:0] O_TX_PARITY,
  input wire logic [NCH-1:0] O_BAUD_TICK,
  input wire logic [NCH-1:0] O_RX_END_IRQ
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);
  AST_ST: assert property (I_RD && I_ADDR == 16'hFFA1 |=> O_RDATA < 8'h08)
    else $error("status high bits");
  AST_B7: assert property (I_RD && I_ADDR == 16'hFFAA |=> !O_RDATA[7])
    else $error("baud bit 7");
  AST_UNM: assert property (I_RD && I_ADDR == 16'h0000 |=> !O_RDATA)
    else $error("unmapped read");
  AST_TXP: assert property (O_TX_PARITY == '0) else $error("parity");
  AST_IRQ: assert property (I_RX_DONE[1] |=> O_RX_END_IRQ[1])
    else $error("irq missing");
  AST_NOIRQ: assert property (O_RX_END_IRQ[1] |-> $past(I_RX_DONE[1]))
    else $error("stray irq");
  AST_SUP: assert property (I_RX_DONE[0] && I_ERROR_IRQ_SUPPRESS &&
    !I_RX_STOP_BIT[0] |=> !O_RX_END_IRQ[0]) else $error("irq not held");
  AST_IRQ0: assert property (I_RX_DONE[0] && !I_ERROR_IRQ_SUPPRESS
    |=> O_RX_END_IRQ[0]) else $error("irq lost");
  // shortest legal baud period is 128 clocks on ch1, 64 on ch0
  AST_TICK: assert property (O_BAUD_TICK[1] |=> !O_BAUD_TICK[1] [*8])
    else $error("tick too soon");
  AST_TICK0: assert property (O_BAUD_TICK[0] |=> !O_BAUD_TICK[0] [*8])
    else $error("ch0 tick too soon");
  cover property (O_BAUD_TICK[0]);
  cover property (I_RX_DONE[0] && I_ERROR_IRQ_SUPPRESS);
  cover property (O_RX_END_IRQ[1]);
endmodule // usbg_chk
bind usbg_top usbg_chk #(.NCH(NCH)) chk_u (.*);
`default_nettype wire

// [verif/usbg_peer.sv]
// remote transmitter model giving per-frame receive results
`timescale 1ns/10ps
`default_nettype none
module usbg_peer (input wire logic i_clk, input wire logic [1:0] i_go,
  input wire logic [2:0] i_bits, output var logic [1:0] o_done,
  output var logic [5:0] o_bits);
  // idle lines toggle so a stale value is never taken as data
  always @(posedge i_clk) o_done <= i_go;
  always @(posedge i_clk) o_bits <= |i_go ? {2{i_bits}} : ~o_bits;
endmodule // usbg_peer
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the status and baud block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, sup = 0;
  logic [15:0] adr = 16'h0000;
  logic [7:0] wd = 8'h00, rdat;
  logic [1:0] go = 2'h0, rbr = 2'h0, dn, tk, irq;
  logic [2:0] bits = 3'h0;
  logic [3:0] pm = 4'h0;
  logic [5:0] ob;
  int fails = 0, total_checks = 0, cyc = 0;
  time t;
  // write flag, address, data; k of all ones is never written
  // no infrared traffic here, so ch0 may use any divide
  logic [24:0] rt [9] = '{25'h0FFA100, 25'h0FFAA00, 25'h1FFA2EE, 25'h0FFA26E,
    25'h1FFA1FF, 25'h0FFA100, 25'h0000000, 25'h1FFA203, 25'h1FFAA1E};
  // channel, mode, data xor, parity, stop, buffer read, suppress, status
  logic [15:0] ft [6] = '{16'h7604, 16'h3902, 16'h5501, 16'h0F01, 16'h6500,
    16'hDD04};
  always #25 clk = ~clk;
  always @(posedge clk) if (++cyc > 4000) end_of_test;
  usbg_peer peer_u (.i_clk(clk), .i_go(go), .i_bits(bits), .o_done(dn),
    .o_bits(ob));
  usbg_top dut_u (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_ADDR(adr), .I_WR(wr),
    .I_RD(rd), .I_WDATA(wd), .O_RDATA(rdat), .I_RX_DONE(dn),
    .I_RX_PAR_BIT({ob[4], ob[1]}), .I_RX_DATA_PAR({ob[3], ob[0]}),
    .I_RX_STOP_BIT({ob[5], ob[2]}), .I_PARITY_MODE(pm), .I_RXBUF_READ(rbr),
    .I_ERROR_IRQ_SUPPRESS(sup), .O_TX_PARITY(), .O_BAUD_TICK(tk),
    .O_RX_END_IRQ(irq));
  task ck(input [15:0] n, e, s);
    total_checks++;
    if (s !== e) fails++;
    if (s !== e) $display("Error %h exp %h got %h", n, e, s);
  endtask
  task end_of_test;
    if (cyc > 4000) fails++;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task acc(input [24:0] x);
    @(posedge clk) {wr, adr, wd, rd} <= {x, !x[24]};
    @(posedge clk) {wr, rd} <= 2'h0;
    @(posedge clk) #1 if (!x[24]) ck(x[23:8], {8'h00, x[7:0]}, {8'h00, rdat});
  endtask
  task per(input int c, input [15:0] e);
    @(posedge clk iff tk[c]) t = $time;
    @(posedge clk iff tk[c]) ck(16'(c), e, 16'(($time - t) / 50));
  endtask
  // baud registers never rewritten while a frame is in flight
  task fr(input [15:0] x);
    @(posedge clk) {pm, bits, sup, go} <= {x[14:13], x[14:13], x[10], x[11],
      x[12], x[8], x[15], !x[15]};
    @(posedge clk) go <= 2'h0;
    @(posedge clk) #1 ck(16'h00E0, {15'h0000, x[15] | !x[8] | ~|x[7:0]},
      {15'h0000, irq[x[15]]});
    acc({1'b0, x[15] ? 16'hFFA9 : 16'hFFA1, x[7:0]});
    @(posedge clk) rbr <= {x[15], !x[15]} & {2{x[9]}};
    @(posedge clk) rbr <= 2'h0;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    foreach (rt[i]) acc(rt[i]);
    per(0, 16'd76);
    per(1, 16'd480);
    foreach (ft[i]) fr(ft[i]);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
